// ==== spc_sdram_pins.sv ====
// Pin-level command, select, mask and clock enable driver for SDRAM.
`timescale 1ns/1ps
module spc_sdram_pins
    import spc_pkg::*;
(
    input  wire logic                  i_ref_clk,          // System clock, 100 MHz.
    input  wire logic                  i_rst,              // Synchronous reset, active high.
    input  wire logic                  i_cmd_valid,        // Command request for this cycle.
    input  wire logic [2:0]            i_cmd_op,           // Requested command, spc_op_type code.
    input  wire logic [SPC_ADDR_W-1:0] i_cmd_addr,         // Word address of the command.
    input  wire logic                  i_cmd_addr10,       // Level for address bit 10.
    input  wire logic                  i_cmd_single,       // Single word access.
    input  wire logic                  i_bus_32,           // Memory configured for a 32-bit bus.
    input  wire logic                  i_bus_master,       // This device owns the external bus.
    input  wire logic                  i_selfref_req,      // Request self-refresh mode.
    input  wire logic                  i_suspend_req,      // Request suspend mode.
    input  wire logic                  i_host_bus_request_n, // Host bus request pin, active low.
    input  wire logic                  i_host_bus_grant_n_in, // Grant pin level from the bus.
    output logic                       o_cmd_ready,        // Command is accepted this cycle.
    output logic      [3:0]            o_sdram_bank_selects, // Select lines, active low.
    output logic                       o_row_strobe_n,     // Row strobe.
    output logic                       o_col_strobe_n,     // Column strobe.
    output logic                       o_sdram_write_enable_n, // Write enable.
    output logic                       o_low_word_mask,    // Low word data mask.
    output logic                       o_high_word_mask,   // High word data mask.
    output logic                       o_sdram_addr_bit10, // Dedicated address bit 10.
    output logic                       o_sdram_clock_enable, // SDRAM clock enable.
    output logic                       o_ctrl_oe,          // Enable for all control outputs.
    output logic                       o_host_bus_grant_n, // Host grant output level.
    output logic                       o_host_bus_grant_oe, // Host grant output enable.
    output logic                       o_in_selfref        // SDRAM held in a low power mode.
);

    // ------------------------------------------------------------------
    // Host request synchroniser
    // ------------------------------------------------------------------
    logic [2:0] hreq_sync_q;                               // Three stage pin sampler.
    logic [2:0] hreq_sync_d;                               // Next sampler value.
    logic       hreq_q;                                    // Filtered request level, high active.
    logic       hreq_d;                                    // Next filtered level.

    // Shift the pin in; change counts when stages two and three agree.
    always_comb begin
        hreq_sync_d = {hreq_sync_q[1:0], ~i_host_bus_request_n};
        hreq_d      = hreq_q;
        if (hreq_sync_q[1] == hreq_sync_q[2]) begin
            hreq_d = hreq_sync_q[2];
        end
    end

    // Register the sampler.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            hreq_sync_q <= 3'h0;
            hreq_q      <= 1'b0;
        end else begin
            hreq_sync_q <= hreq_sync_d;
            hreq_q      <= hreq_d;
        end
    end

    // ------------------------------------------------------------------
    // Power and grant state machine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN,        // Normal operation, clock enable high.
        ST_ENTER_SR,   // Issue self-refresh entry command.
        ST_PARK,       // Entry command driven to the memory, grant still withheld.
        ST_SELFREF,    // Self-refresh held.
        ST_SUSPEND,    // Suspend held.
        ST_GRANTED,    // Bus handed to the host.
        ST_EXIT        // Clock enable raised, one settle cycle.
    } spc_state_type;

    spc_state_type state_q;                                // Current state.
    spc_state_type state_d;                                // Next state.
    logic          host_sr_q;                              // Self-refresh entered for the host.
    logic          host_sr_d;                              // Next value.

    // Next state logic for self-refresh, suspend and host grant.
    always_comb begin
        state_d   = state_q;
        host_sr_d = host_sr_q;
        unique case (state_q)
            ST_RUN: begin
                if (i_bus_master && hreq_q) begin
                    state_d   = ST_ENTER_SR;
                    host_sr_d = 1'b1;
                end else if (i_selfref_req) begin
                    state_d   = ST_ENTER_SR;
                end else if (i_suspend_req) begin
                    state_d   = ST_SUSPEND;
                end
            end
            ST_ENTER_SR: begin
                state_d = host_sr_q ? ST_PARK : ST_SELFREF;
            end
            // The refresh entry must reach the pins while they are still driven.
            ST_PARK: begin
                state_d = ST_GRANTED;
            end
            ST_SELFREF: begin
                if (!i_selfref_req) begin
                    state_d = ST_EXIT;
                end
            end
            ST_SUSPEND: begin
                if (!i_suspend_req) begin
                    state_d = ST_EXIT;
                end
            end
            ST_GRANTED: begin
                if (!hreq_q) begin
                    state_d   = ST_EXIT;
                    host_sr_d = 1'b0;
                end
            end
            ST_EXIT: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // Register the power state.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q   <= ST_RUN;
            host_sr_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            host_sr_q <= host_sr_d;
        end
    end

    // ------------------------------------------------------------------
    // Command encoding and masks
    // ------------------------------------------------------------------
    logic       in_space;                                  // Address is in SDRAM space.
    logic [3:0] dec_sel_n;                                 // Decoded select lines.
    logic [3:0] sel_d;                                     // Next select lines.
    logic [3:0] sel_q;                                     // Registered select lines.
    logic [2:0] cmd_d;                                     // Next {row, column, write}.
    logic [2:0] cmd_q;                                     // Registered strobes.
    logic [1:0] mask_d;                                    // Next {high, low} masks.
    logic [1:0] mask_q;                                    // Registered masks.
    logic       a10_d;                                     // Next address bit 10.
    logic       a10_q;                                     // Registered address bit 10.
    logic       cke_d;                                     // Next clock enable.
    logic       cke_q;                                     // Registered clock enable.
    logic       take;                                      // Command is issued this cycle.

    // Select decode of the command address.
    spc_decode u_decode (
        .i_addr     (i_cmd_addr),
        .o_in_space (in_space),
        .o_sel_n    (dec_sel_n)
    );

    // Commands are taken only in normal operation as master.
    assign o_cmd_ready = (state_q == ST_RUN) && i_bus_master;
    assign take        = i_cmd_valid && o_cmd_ready;

    // Build the strobe, select, mask, address bit and clock enable levels.
    always_comb begin
        cmd_d  = SPC_CMD_NOP;
        sel_d  = SPC_SEL_IDLE;
        mask_d = 2'h0;
        a10_d  = a10_q;
        cke_d  = 1'b1;
        if (take) begin
            a10_d = i_cmd_addr10;
            unique case (spc_op_type'(i_cmd_op))
                SPC_OP_ACT:   cmd_d = SPC_CMD_ACT;
                SPC_OP_READ:  cmd_d = SPC_CMD_READ;
                SPC_OP_WRITE: begin
                    cmd_d     = SPC_CMD_WRITE;
                    mask_d[0] = !i_bus_32 && i_cmd_addr[0];
                    mask_d[1] = i_bus_32 || (i_cmd_single && !i_cmd_addr[0]);
                end
                SPC_OP_PRE:   cmd_d = SPC_CMD_PRE;
                SPC_OP_REF:   cmd_d = SPC_CMD_REF;
                SPC_OP_MRS:   cmd_d = SPC_CMD_MRS;
                default:      cmd_d = SPC_CMD_NOP;
            endcase
            // Masks stay low on reads and whenever the column strobe is idle.
            if (cmd_d[1]) begin
                mask_d = 2'h0;
            end
            // Refresh and mode set reach every device; others use the decode.
            if (cmd_d == SPC_CMD_REF || cmd_d == SPC_CMD_MRS) begin
                sel_d = 4'h0;
            end else if (cmd_d != SPC_CMD_NOP && in_space) begin
                sel_d = dec_sel_n;
            end
        end
        if (state_q == ST_ENTER_SR) begin
            cmd_d = SPC_CMD_REF;
            sel_d = 4'h0;
            cke_d = 1'b0;
        end else if (state_q inside {ST_SELFREF, ST_SUSPEND, ST_PARK, ST_GRANTED}) begin
            cke_d = (state_d == ST_EXIT);
        end
    end

    // Register the pin levels.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cmd_q  <= SPC_CMD_NOP;
            sel_q  <= SPC_SEL_IDLE;
            mask_q <= 2'h0;
            a10_q  <= 1'b0;
            cke_q  <= SPC_CKE_RESET;
        end else begin
            cmd_q  <= cmd_d;
            sel_q  <= sel_d;
            mask_q <= mask_d;
            a10_q  <= a10_d;
            cke_q  <= cke_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin outputs and drive enables
    // ------------------------------------------------------------------
    assign o_sdram_bank_selects   = sel_q;
    assign o_row_strobe_n         = cmd_q[2];
    assign o_col_strobe_n         = cmd_q[1];
    assign o_sdram_write_enable_n = cmd_q[0];
    assign o_low_word_mask        = mask_q[0];
    assign o_high_word_mask       = mask_q[1];
    assign o_sdram_addr_bit10     = a10_q;
    assign o_sdram_clock_enable   = cke_q;
    assign o_in_selfref           = !cke_q;
    // Only the master drives, and never while the host holds the bus.
    assign o_ctrl_oe              = i_bus_master && (state_q != ST_GRANTED);
    // Grant is driven by the master, low while the host owns the bus.
    assign o_host_bus_grant_n     = (state_q != ST_GRANTED);
    assign o_host_bus_grant_oe    = i_bus_master || (state_q == ST_GRANTED);

endmodule // spc_sdram_pins

// ==== spc_pkg.sv ====
// Package of constants for the SDRAM pin control block.
//
// Notes on behaviour
// - Assert a select on SDRAM-space command cycles.
// - Only bus master drives select lines.
// - Row strobe high on read/write; else encoding.
// - Column strobe low on read/write; else encoding.
// - Write enable low write, high read.
// - Masks valid with column strobe; idle on reads.
// - Odd word on 64-bit bus masks low.
// - Even single word or 32-bit bus masks high.
// - Separate address bit 10 output for refresh.
// - Clock enable low in self-refresh or suspend.
// - Host grant: self-refresh first, then three-state.
package spc_pkg;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    localparam int          SPC_ADDR_W      = 32;          // Width of the access address.
    localparam logic [1:0]  SPC_SPACE_SDRAM = 2'h1;        // Top two address bits of SDRAM space.
    localparam int          SPC_SEL_HI      = 27;          // Upper bit of the select decode field.
    localparam int          SPC_SEL_LO      = 26;          // Lower bit of the select decode field.
    localparam logic [3:0]  SPC_RSV_FIELD   = 4'hF;        // Bits 29:26 pattern that is reserved.

    // ------------------------------------------------------------------
    // Command codes as {row, column, write} strobe levels
    // ------------------------------------------------------------------
    localparam logic [2:0]  SPC_CMD_NOP     = 3'h7;        // No operation.
    localparam logic [2:0]  SPC_CMD_ACT     = 3'h3;        // Activate row.
    localparam logic [2:0]  SPC_CMD_READ    = 3'h5;        // Column read.
    localparam logic [2:0]  SPC_CMD_WRITE   = 3'h4;        // Column write.
    localparam logic [2:0]  SPC_CMD_PRE     = 3'h2;        // Precharge.
    localparam logic [2:0]  SPC_CMD_REF     = 3'h1;        // Auto or self refresh.
    localparam logic [2:0]  SPC_CMD_MRS     = 3'h0;        // Mode register set.

    // ------------------------------------------------------------------
    // Commands that the controller may request
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SPC_OP_NOP,
        SPC_OP_ACT,
        SPC_OP_READ,
        SPC_OP_WRITE,
        SPC_OP_PRE,
        SPC_OP_REF,
        SPC_OP_MRS
    } spc_op_type;

    // Reset values of the pins.
    localparam logic [3:0]  SPC_SEL_IDLE    = 4'hF;        // All selects inactive (active low).
    localparam logic        SPC_CKE_RESET   = 1'h1;        // Clock enable high after reset.

endpackage : spc_pkg

// ==== spc_decode.sv ====
// Address decode of the SDRAM space into four select lines.
`timescale 1ns/1ps
module spc_decode
    import spc_pkg::*;
(
    input  wire logic [SPC_ADDR_W-1:0] i_addr,      // Access address.
    output logic                       o_in_space,  // Address lies in usable SDRAM space.
    output logic      [3:0]            o_sel_n      // One-cold select lines.
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Space test excludes the reserved pattern and picks one line only.
    always_comb begin
        o_in_space = (i_addr[SPC_ADDR_W-1 -: 2] == SPC_SPACE_SDRAM) &&
                     (i_addr[29:26] != SPC_RSV_FIELD);
        o_sel_n    = SPC_SEL_IDLE;
        if (o_in_space) begin
            o_sel_n[i_addr[SPC_SEL_HI:SPC_SEL_LO]] = 1'b0;
        end
    end

endmodule // spc_decode

// ==== spc_pins_checker.sv ====
// Concurrent checks on the ports of the SDRAM pin control block.
`timescale 1ns/1ps
module spc_pins_checker
    import spc_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_cmd_valid,
    input  wire logic [2:0]  i_cmd_op,
    input  wire logic [31:0] i_cmd_addr,
    input  wire logic        i_cmd_addr10,
    input  wire logic        i_bus_32,
    input  wire logic        i_bus_master,
    input  wire logic        o_cmd_ready,
    input  wire logic [3:0]  o_sdram_bank_selects,
    input  wire logic        o_row_strobe_n,
    input  wire logic        o_col_strobe_n,
    input  wire logic        o_sdram_write_enable_n,
    input  wire logic        o_low_word_mask,
    input  wire logic        o_high_word_mask,
    input  wire logic        o_sdram_addr_bit10,
    input  wire logic        o_sdram_clock_enable,
    input  wire logic        o_ctrl_oe,
    input  wire logic        o_host_bus_grant_n,
    input  wire logic        o_host_bus_grant_oe,
    input  wire logic        o_in_selfref
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic       take;  // A command is accepted at this edge.
    logic       rw;    // The accepted command is a read or a write.
    logic [1:0] pick;  // Select field of the address.
    logic [2:0] pins;  // Row, column and write strobes together.
    assign take = i_cmd_valid && o_cmd_ready;
    assign rw   = i_cmd_op == SPC_OP_READ || i_cmd_op == SPC_OP_WRITE;
    assign pick = i_cmd_addr[SPC_SEL_HI:SPC_SEL_LO];
    assign pins = {o_row_strobe_n, o_col_strobe_n, o_sdram_write_enable_n};

    write_code_a: assert property (take && i_cmd_op == SPC_OP_WRITE |=> pins == SPC_CMD_WRITE)
        else $error("write strobes wrong");
    read_code_a: assert property (take && i_cmd_op == SPC_OP_READ |=> pins == SPC_CMD_READ)
        else $error("read strobes wrong");
    sel_one_a: assert property (take && rw && i_cmd_addr[31:30] == SPC_SPACE_SDRAM
        && i_cmd_addr[29:26] != SPC_RSV_FIELD |=> o_sdram_bank_selects == ~(4'h1 << $past(pick)))
        else $error("select decode wrong");
    sel_out_a: assert property (take && rw && i_cmd_addr[31:30] != SPC_SPACE_SDRAM
        |=> &o_sdram_bank_selects)
        else $error("select outside space");
    master_only_a: assert property (!i_bus_master |-> !o_ctrl_oe && !o_cmd_ready)
        else $error("slave drives pins");
    mask_write_a: assert property (o_low_word_mask || o_high_word_mask |-> pins == SPC_CMD_WRITE)
        else $error("mask outside write");
    low_odd_a: assert property (take && i_cmd_op == SPC_OP_WRITE && i_cmd_addr[0] && !i_bus_32
        |=> o_low_word_mask && !o_high_word_mask)
        else $error("odd word mask wrong");
    high_narrow_a: assert property (take && i_cmd_op == SPC_OP_WRITE && i_bus_32
        |=> o_high_word_mask && !o_low_word_mask)
        else $error("narrow bus mask wrong");
    addr_bit10_a: assert property (take && i_cmd_op != SPC_OP_NOP
        |=> o_sdram_addr_bit10 == $past(i_cmd_addr10))
        else $error("address bit 10 wrong");
    low_power_a: assert property (take |-> o_sdram_clock_enable && !o_in_selfref)
        else $error("command while asleep");
    grant_park_a: assert property (!o_host_bus_grant_n && o_host_bus_grant_oe
        |-> !o_sdram_clock_enable && !o_ctrl_oe)
        else $error("grant while pins driven");
    sr_first_a: assert property ($fell(o_host_bus_grant_n)
        |-> $past(o_ctrl_oe) && $past(pins) == SPC_CMD_REF && !$past(o_sdram_clock_enable)
        && $past(o_sdram_bank_selects) == 4'h0)
        else $error("grant before self-refresh");

    write_seen_c: cover property (take && i_cmd_op == SPC_OP_WRITE);
    grant_seen_c: cover property (!o_host_bus_grant_n && o_host_bus_grant_oe);
    sleep_seen_c: cover property (o_in_selfref);
endmodule // spc_pins_checker

bind spc_sdram_pins spc_pins_checker u_spc_pins_checker (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
    .i_cmd_addr(i_cmd_addr), .i_cmd_addr10(i_cmd_addr10), .i_bus_32(i_bus_32), .i_bus_master(i_bus_master),
    .o_cmd_ready(o_cmd_ready), .o_sdram_bank_selects(o_sdram_bank_selects), .o_row_strobe_n(o_row_strobe_n),
    .o_col_strobe_n(o_col_strobe_n), .o_sdram_write_enable_n(o_sdram_write_enable_n),
    .o_low_word_mask(o_low_word_mask), .o_high_word_mask(o_high_word_mask),
    .o_sdram_addr_bit10(o_sdram_addr_bit10), .o_sdram_clock_enable(o_sdram_clock_enable),
    .o_ctrl_oe(o_ctrl_oe), .o_host_bus_grant_n(o_host_bus_grant_n),
    .o_host_bus_grant_oe(o_host_bus_grant_oe), .o_in_selfref(o_in_selfref));

// ==== spc_sdram_model.sv ====
// Behavioural SDRAM that watches its command pins and tracks self-refresh.
`timescale 1ns/1ps
module spc_sdram_model (
    input  wire logic       i_ref_clk,
    input  wire logic [3:0] i_sel_n,
    input  wire logic [2:0] i_cmd,
    input  wire logic       i_cke,
    input  wire logic       i_oe,
    output logic            o_asleep
);
    // A selected refresh with clock enable low puts the memory to sleep; clock enable high wakes it.
    initial o_asleep = 1'b0;
    always @(posedge i_ref_clk) begin
        if (i_oe && i_sel_n != 4'hF && i_cmd == 3'h1 && !i_cke) o_asleep <= 1'b1;
        else if (i_cke) o_asleep <= 1'b0;
    end
endmodule // spc_sdram_model

// ==== sdram_pin_control_test.sv ====
// Self-checking testbench for the SDRAM pin control block.
`timescale 1ns/1ps
module sdram_pin_control_test;
    import spc_pkg::*;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, valid = 1'b0, a10 = 1'b0, single = 1'b0, bus32 = 1'b0;
    logic master = 1'b1, sr_req = 1'b0, sus_req = 1'b0, hreq_n = 1'b1;
    logic [2:0]  op = 3'h0;
    logic [31:0] addr = 32'h0;
    logic ready, row_n, col_n, we_n, lmask, hmask, sa10, cke, oe, gnt_n, gnt_oe, in_sr, asleep;
    logic [3:0]  sel_n;
    wire         grant_wire;
    int          mismatches = 0, total_checks = 0;
    logic [2:0]  codes [7] = '{SPC_CMD_NOP, SPC_CMD_ACT, SPC_CMD_READ, SPC_CMD_WRITE,
                               SPC_CMD_PRE, SPC_CMD_REF, SPC_CMD_MRS};

    always #5 i_ref_clk = ~i_ref_clk;
    // The grant line has a pull-up, so it reads high whenever nobody drives it.
    assign grant_wire = gnt_oe ? gnt_n : 1'b1;

    spc_sdram_pins u_spc_sdram_pins (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(valid),
        .i_cmd_op(op), .i_cmd_addr(addr), .i_cmd_addr10(a10), .i_cmd_single(single), .i_bus_32(bus32),
        .i_bus_master(master), .i_selfref_req(sr_req), .i_suspend_req(sus_req),
        .i_host_bus_request_n(hreq_n), .i_host_bus_grant_n_in(grant_wire), .o_cmd_ready(ready),
        .o_sdram_bank_selects(sel_n), .o_row_strobe_n(row_n), .o_col_strobe_n(col_n),
        .o_sdram_write_enable_n(we_n), .o_low_word_mask(lmask), .o_high_word_mask(hmask),
        .o_sdram_addr_bit10(sa10), .o_sdram_clock_enable(cke), .o_ctrl_oe(oe),
        .o_host_bus_grant_n(gnt_n), .o_host_bus_grant_oe(gnt_oe), .o_in_selfref(in_sr));
    spc_sdram_model u_spc_sdram_model (.i_ref_clk(i_ref_clk), .i_sel_n(sel_n),
        .i_cmd({row_n, col_n, we_n}), .i_cke(cke), .i_oe(oe), .o_asleep(asleep));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds one command from a falling edge; on return the pins show it.
    task automatic issue(input logic [2:0] o, input logic [31:0] a, input logic b10, s, b32);
        op = o;
        addr = a;
        a10 = b10;
        single = s;
        bus32 = b32;
        valid = 1'b1;
        @(negedge i_ref_clk);
    endtask

    // Selects expected for a command: none outside the usable space, all for refresh and mode set.
    function automatic logic [3:0] exp_sel(input logic [2:0] o, input logic [31:0] a);
        if (o == SPC_OP_REF || o == SPC_OP_MRS) return 4'h0;
        if (a[31:30] == 2'h1 && a[29:26] != 4'hF) return ~(4'h1 << a[27:26]);
        return 4'hF;
    endfunction

    task automatic idle(input int n);
        valid = 1'b0;
        repeat (n) @(negedge i_ref_clk);
    endtask

    task automatic t_reset();
        check("reset selects", 8'h0F, sel_n);
        check("reset strobes", SPC_CMD_NOP, {row_n, col_n, we_n});
        check("reset pins", 8'h01, {lmask, hmask, sa10, cke});
    endtask

    // Every command but no-op back to back, over all four selects and outside or reserved addresses.
    task automatic t_commands();
        logic [31:0] al [4] = '{32'h8000_0000, 32'h7C00_0000, 32'h7800_0000, 32'h0000_0004};
        logic [31:0] a;
        for (int k = 1; k < 11; k++) begin
            a = (k < 7) ? (32'h4000_0000 | (32'(k % 4) << 26)) : al[k - 7];
            issue((k < 7) ? 3'(k) : SPC_OP_READ, a, k[0], 1'b0, 1'b0);
            check("strobes", codes[op], {row_n, col_n, we_n});
            check("selects", exp_sel(op, a), sel_n);
            check("addr bit 10", k[0], sa10);
        end
        // A new level with no command must not reach the pin.
        a10 = 1'b1;
        idle(1);
        check("idle strobes", SPC_CMD_NOP, {row_n, col_n, we_n});
        check("addr bit 10 held", 8'h00, sa10);
    endtask

    // Each case is {write, odd, single, narrow bus, low mask, high mask}.
    task automatic t_masks();
        logic [5:0] cs [6] = '{6'h3A, 6'h29, 6'h20, 6'h35, 6'h14, 6'h3D};
        for (int k = 0; k < 6; k++) begin
            issue(cs[k][5] ? SPC_OP_WRITE : SPC_OP_READ, {31'h2000_0000, cs[k][4]}, 1'b0, cs[k][3], cs[k][2]);
            check("masks", cs[k][1:0], {lmask, hmask});
        end
        idle(1);
        check("idle masks", 8'h00, {lmask, hmask});
    endtask

    task automatic t_master();
        master = 1'b0;
        @(negedge i_ref_clk);
        check("slave ready and enable", 8'h00, {ready, oe});
        master = 1'b1;
        @(negedge i_ref_clk);
        check("master enable", 8'h01, oe);
    endtask

    // Self-refresh, then suspend, each entered and left again.
    task automatic t_low_power();
        sr_req = 1'b1;
        for (int n = 0; n < 10 && cke !== 1'b0; n++) @(negedge i_ref_clk);
        // The memory takes the entry command at the edge after the pins show it.
        @(negedge i_ref_clk);
        check("self-refresh state", 8'h07, {cke, asleep, in_sr, ~ready});
        sr_req = 1'b0;
        for (int n = 0; n < 10 && ready !== 1'b1; n++) @(negedge i_ref_clk);
        check("awake again", 8'h06, {cke, ready, asleep});
        sus_req = 1'b1;
        for (int n = 0; n < 10 && cke !== 1'b0; n++) @(negedge i_ref_clk);
        check("suspend state", 8'h07, {cke, asleep, row_n, col_n, we_n});
        sus_req = 1'b0;
        for (int n = 0; n < 10 && ready !== 1'b1; n++) @(negedge i_ref_clk);
        check("resumed", 8'h03, {cke, ready});
    endtask

    // A host takes the bus: memory sleeps and the pins float in the same cycle as the grant shows.
    task automatic t_host();
        hreq_n = 1'b0;
        for (int n = 0; n < 20 && grant_wire !== 1'b0; n++) @(negedge i_ref_clk);
        check("granted state", 8'h04, {grant_wire, cke, asleep, oe, ready});
        hreq_n = 1'b1;
        for (int n = 0; n < 20 && ready !== 1'b1; n++) @(negedge i_ref_clk);
        check("bus back", 8'h0F, {grant_wire, cke, oe, ready});
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge i_ref_clk);
        i_rst = 1'b0;
        @(negedge i_ref_clk);
        t_reset();
        t_commands();
        t_masks();
        t_master();
        t_low_power();
        t_host();
        report_and_stop();
    end

    // Watchdog: the whole sequence needs well under a hundred cycles; the limit is 2000.
    initial begin
        #20000;
        mismatches++;
        report_and_stop();
    end
endmodule // sdram_pin_control_test
